// >>> rtl/rwc_top.sv
// reset, sleep and wake-up sequencer with port registers
// Notes on behaviour
// - reset from power-on, pin, watchdog timeout
// - hold reset 18ms, 500ms in slow crystal; only pin and watchdog resets are held, power-on reset is not
// - reset restarts at address zero, oscillator runs
// - reset makes every port pin input
// - reset clears watchdog and prescaler
// - bank switch cleared only at power-on
// - pin and watchdog resets clear timer options except bit six; power-on clears all
// - reset sets pull and open-drain bits
// - reset clears flags, watchdog and enables
// - sleep stops oscillator, ticks; clears watchdog
// - four wake sources, all but the reset pin gated by enable
// - pin or watchdog wake resets, sets status
// - change wake continues, vectors if enabled
// - change wake waits oscillator settle time
// - enabled watchdog masks all wake enables
// - ports tri-state, port5 pins 2,3 output-only
// - port data and direction read-write
// - awake pin change vectors or continues
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module rwc_top
   import rwc_pkg::*;
#(
   parameter int RST_CYC   = RST_HOLD_CYC,
   parameter int LRST_CYC  = LXT_RST_CYC,
   parameter int WDT_CYC   = WDT_TO_CYC,
   parameter int HWAKE_CYC = HXT_WAKE_CYC,
   parameter int LWAKE_CYC = LXT_WAKE_CYC
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // register bus
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   // pins and core side
   input  wire logic          ext_reset_n,
   input  wire logic          comparator_out,
   input  wire logic [31:0]   port_in,
   output logic [31:0]        port_out,
   output logic [31:0]        port_oe_n,
   output logic [7:0]         pad_pullhigh,
   output logic [7:0]         pad_pulldown,
   output logic [7:0]         pad_opendrain,
   output logic               cpu_hold,
   output logic               osc_run,
   output logic               tick_run,
   output logic               pc_load,
   output logic [9:0]         program_counter
);

   ////////////////////////////////////////////////////////////
   // state and registers

   rwc_state_e state;
   rwc_state_e next_state;

   logic [7:0]  timer_option_reg;
   logic [7:0]  memory_bank_switch_reg;
   logic [7:0]  pullhigh_ctrl_reg;
   logic [7:0]  pulldown_ctrl_reg;
   logic [7:0]  opendrain_ctrl_reg;
   logic [7:0]  irq_flag_reg;
   logic [7:0]  watchdog_ctrl_reg;
   logic [7:0]  irq_enable_reg;
   logic [7:0]  wake_ctrl_reg;
   logic [1:0]  osc_mode;
   logic [7:0]  port_data [4];
   logic [7:0]  port_dir  [4];
   logic        to_flag;
   logic        pd_flag;
   logic [31:0] wdt_cnt;
   logic        cmp_q;

   ////////////////////////////////////////////////////////////
   // decode

   wire         wr_go   = awvalid && wvalid && !awready && !bvalid;
   wire         rd_go   = arvalid && !arready && !rvalid;
   wire         wr_hit  = rwc_hit(awaddr);
   wire         rd_hit  = rwc_hit(araddr);
   wire         wr_en   = wr_go && wr_hit && wstrb[0];
   wire [7:0]   wbyte   = wdata[7:0];
   wire [1:0]   wr_idx  = awaddr[3:2];
   wire [1:0]   rd_idx  = araddr[3:2];
   wire         wr_data = wr_en && (awaddr[7:4] == OFF_DATA[7:4]);
   wire         wr_dir  = wr_en && (awaddr[7:4] == OFF_DIR[7:4]);
   wire         wr_cmd  = wr_en && (awaddr == OFF_CMD);

   wire         sleep_instruction        = wr_cmd && wbyte[CMD_SLEEP];
   wire         global_irq_enable_instr  = wr_cmd && wbyte[CMD_ENI];
   wire         global_irq_disable_instr = wr_cmd && wbyte[CMD_GLOBAL_IRQ_DISABLE_INSTR];
   wire         wdt_clear_instr          = wr_cmd && wbyte[CMD_WDTC];

   wire         gie                  = timer_option_reg[TOPT_GIE];
   wire         wdt_on               = watchdog_ctrl_reg[WDT_EN];
   wire         pin_change_wake_en   = wake_ctrl_reg[WAKE_PCHG];
   wire         comparator_wake_en   = wake_ctrl_reg[WAKE_CMP];
   wire         pin_change_irq_en    = irq_enable_reg[FLG_PCHG];
   wire         comparator_irq_en    = irq_enable_reg[FLG_CMP];

   // reading port6 refreshes the change snapshot
   wire         port6_read = rd_go && (araddr == OFF_DATA + 8'h04);
   wire         pchg;
   wire         cmp_chg = (comparator_out != cmp_q) && (state != S_RST);
   wire         in_rst  = (state == S_RST);

   ////////////////////////////////////////////////////////////
   // watchdog and reset sources

   wire [31:0]  wdt_lim = 32'(WDT_CYC) << watchdog_ctrl_reg[2:0];
   wire         wdt_to  = wdt_on && !in_rst && (wdt_cnt >= wdt_lim - 32'h1);
   wire         rst_evt = !ext_reset_n || wdt_to;

   // change wake only while the watchdog is off
   wire         wake_go = (state == S_SLEEP) && !wdt_on &&
                          ((pchg && pin_change_wake_en) ||
                           (cmp_chg && comparator_wake_en));

   wire         run_irq = (state == S_RUN) && gie &&
                          ((pchg && pin_change_irq_en) ||
                           (cmp_chg && comparator_irq_en));

   wire         tmr_done;
   wire         tmr_load = rst_evt || wake_go;
   wire [31:0]  rst_len  = (osc_mode == OSC_LOW_SPEED_CRYSTAL_MODE) ? 32'(LRST_CYC) : 32'(RST_CYC);
   wire [31:0]  wake_len = (osc_mode == OSC_LOW_SPEED_CRYSTAL_MODE) ? 32'(LWAKE_CYC) :
                           (osc_mode == OSC_HIGH_SPEED_CRYSTAL_MODE) ? 32'(HWAKE_CYC) :
                           32'(IRC_WAKE_CYC);
   wire [31:0]  tmr_val  = rst_evt ? rst_len : wake_len;

   rwc_timer #(
      .W (32)
   ) u_timer (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   rwc_chg_det #(
      .W (8)
   ) u_chg (
      .aclk    (aclk),
      .aresetn (aresetn),
      .snap    (port6_read),
      .pins    (port_in[15:8]),
      .chg     (pchg)
   );

   ////////////////////////////////////////////////////////////
   // sequencer

   always_comb begin
      next_state = state;
      if (rst_evt) begin
         next_state = S_RST;
      end else begin
         unique case (state)
            S_RST: begin
               if (tmr_done) begin
                  next_state = S_RUN;
               end
            end
            S_RUN: begin
               if (sleep_instruction) begin
                  next_state = S_SLEEP;
               end
            end
            S_SLEEP: begin
               if (wake_go) begin
                  next_state = S_WAKE;
               end
            end
            S_WAKE: begin
               if (tmr_done) begin
                  next_state = S_RUN;
               end
            end
         endcase
      end
   end

   wire rst_leave  = in_rst && !rst_evt && tmr_done;
   wire wake_leave = (state == S_WAKE) && !rst_evt && tmr_done;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= S_RST;
      end else begin
         state <= next_state;
      end
   end

   // core handshake: restart address and hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_load         <= 1'b0;
         program_counter <= PC_RESET;
         cpu_hold        <= 1'b1;
         osc_run         <= 1'b1;
         tick_run        <= 1'b0;
      end else begin
         pc_load  <= rst_leave || (wake_leave && gie) || run_irq;
         if (rst_leave) begin
            program_counter <= PC_RESET;
         end else if ((wake_leave && gie) || run_irq) begin
            program_counter <= PC_VECTOR;
         end
         cpu_hold <= (next_state != S_RUN);
         osc_run  <= (next_state != S_SLEEP);
         tick_run <= (next_state == S_RUN);
      end
   end

   // watchdog runs in sleep, cleared by reset, sleep and clear command
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_cnt <= 32'h0;
         cmp_q   <= 1'b0;
      end else begin
         cmp_q <= comparator_out;
         if (rst_evt || in_rst || sleep_instruction || wdt_clear_instr || !wdt_on) begin
            wdt_cnt <= 32'h0;
         end else begin
            wdt_cnt <= wdt_cnt + 32'h1;
         end
      end
   end

   // status: which source caused the last reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         to_flag <= 1'b0;
         pd_flag <= 1'b0;
      end else if (rst_evt && !in_rst) begin
         to_flag <= wdt_to;
         pd_flag <= (state == S_SLEEP) || (state == S_WAKE);
      end
   end

   ////////////////////////////////////////////////////////////
   // software registers

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         memory_bank_switch_reg <= RST_ZERO;
         osc_mode               <= OSC_IRC;
         timer_option_reg       <= RST_ZERO;
      end else begin
         if (wr_en && awaddr == OFF_BANK) begin
            memory_bank_switch_reg <= wbyte;
         end
         if (wr_en && awaddr == OFF_OSC) begin
            osc_mode <= wbyte[1:0];
         end
         if (rst_evt || in_rst) begin
            timer_option_reg <= RST_ZERO | (timer_option_reg & (8'h01 << TOPT_GIE));
         end else if (global_irq_enable_instr) begin
            timer_option_reg[TOPT_GIE] <= 1'b1;
         end else if (global_irq_disable_instr) begin
            timer_option_reg[TOPT_GIE] <= 1'b0;
         end else if (wr_en && awaddr == OFF_TOPT) begin
            timer_option_reg <= wbyte;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || rst_evt || in_rst) begin
         pullhigh_ctrl_reg  <= RST_ONES;
         pulldown_ctrl_reg  <= RST_ONES;
         opendrain_ctrl_reg <= RST_ONES;
         watchdog_ctrl_reg  <= RST_ZERO;
         irq_enable_reg     <= RST_ZERO;
         wake_ctrl_reg      <= RST_ZERO;
      end else if (wr_en) begin
         unique case (awaddr)
            OFF_PHI:  pullhigh_ctrl_reg  <= wbyte;
            OFF_PLO:  pulldown_ctrl_reg  <= wbyte;
            OFF_ODR:  opendrain_ctrl_reg <= wbyte;
            OFF_WDT:  watchdog_ctrl_reg  <= wbyte;
            OFF_IEN:  irq_enable_reg     <= wbyte;
            OFF_WAKE: wake_ctrl_reg      <= wbyte;
            default:  ;
         endcase
      end
   end

   // flags: write one to clear, a new event wins over the clear
   wire [7:0] flag_clr = (wr_en && awaddr == OFF_IFLG) ? wbyte : 8'h00;
   wire [7:0] flag_set = (8'(pchg && !in_rst) << FLG_PCHG) |
                         (8'(cmp_chg) << FLG_CMP);

   always_ff @(posedge aclk) begin
      if (!aresetn || rst_evt || in_rst) begin
         irq_flag_reg <= RST_ZERO;
      end else begin
         irq_flag_reg <= (irq_flag_reg & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || rst_evt || in_rst) begin
         for (int i = 0; i < 4; i++) begin
            port_data[i] <= RST_ZERO;
            port_dir[i]  <= RST_ONES;
         end
      end else begin
         if (wr_data) begin
            port_data[wr_idx] <= wbyte;
         end
         if (wr_dir) begin
            port_dir[wr_idx] <= wbyte;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // pads

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_out      <= 32'h0;
         port_oe_n     <= 32'hFFFFFFFF;
         pad_pullhigh  <= RST_ONES;
         pad_pulldown  <= RST_ONES;
         pad_opendrain <= RST_ONES;
      end else begin
         for (int i = 0; i < 4; i++) begin
            port_out[i*8 +: 8]  <= port_data[i];
            port_oe_n[i*8 +: 8] <= (next_state == S_RST) ? RST_ONES : port_dir[i];
         end
         if (next_state != S_RST) begin
            port_oe_n[P5_OUT_LO] <= 1'b0;
            port_oe_n[P5_OUT_HI] <= 1'b0;
         end
         pad_pullhigh  <= pullhigh_ctrl_reg;
         pad_pulldown  <= pulldown_ctrl_reg;
         pad_opendrain <= opendrain_ctrl_reg;
      end
   end

   ////////////////////////////////////////////////////////////
   // register bus slave

   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (araddr[7:4] == OFF_DATA[7:4]) begin
         rd_byte = port_in[rd_idx*8 +: 8];
      end else if (araddr[7:4] == OFF_DIR[7:4]) begin
         rd_byte = port_dir[rd_idx];
      end else begin
         unique case (araddr)
            OFF_TOPT: rd_byte = timer_option_reg;
            OFF_BANK: rd_byte = memory_bank_switch_reg;
            OFF_STAT: rd_byte = (8'(to_flag) << STAT_TO) | (8'(pd_flag) << STAT_PD) |
                                8'(state);
            OFF_PHI:  rd_byte = pullhigh_ctrl_reg;
            OFF_PLO:  rd_byte = pulldown_ctrl_reg;
            OFF_ODR:  rd_byte = opendrain_ctrl_reg;
            OFF_IFLG: rd_byte = irq_flag_reg;
            OFF_WDT:  rd_byte = watchdog_ctrl_reg;
            OFF_IEN:  rd_byte = irq_enable_reg;
            OFF_WAKE: rd_byte = wake_ctrl_reg;
            OFF_OSC:  rd_byte = {6'h00, osc_mode};
            default:  rd_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rresp   <= 2'h0;
         rdata   <= 32'h0;
      end else begin
         awready <= wr_go;
         wready  <= wr_go;
         arready <= rd_go;
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? 2'h0 : 2'h2;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         if (rd_go) begin
            rvalid <= 1'b1;
            rresp  <= rd_hit ? 2'h0 : 2'h2;
            rdata  <= {24'h0, rd_hit ? rd_byte : 8'h00};
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule

// >>> rtl/rwc_pkg.sv
// constants, register map and types of the reset and wake controller
package rwc_pkg;

   localparam int AW = 8;

   // register byte offsets
   localparam logic [AW-1:0] OFF_CMD    = 8'h00;
   localparam logic [AW-1:0] OFF_TOPT   = 8'h04;
   localparam logic [AW-1:0] OFF_BANK   = 8'h08;
   localparam logic [AW-1:0] OFF_STAT   = 8'h0C;
   localparam logic [AW-1:0] OFF_PHI    = 8'h10;
   localparam logic [AW-1:0] OFF_PLO    = 8'h14;
   localparam logic [AW-1:0] OFF_ODR    = 8'h18;
   localparam logic [AW-1:0] OFF_IFLG   = 8'h1C;
   localparam logic [AW-1:0] OFF_WDT    = 8'h20;
   localparam logic [AW-1:0] OFF_IEN    = 8'h24;
   localparam logic [AW-1:0] OFF_WAKE   = 8'h28;
   localparam logic [AW-1:0] OFF_OSC    = 8'h2C;
   localparam logic [AW-1:0] OFF_DATA   = 8'h30;
   localparam logic [AW-1:0] OFF_DIR    = 8'h40;
   localparam logic [AW-1:0] OFF_LAST   = 8'h4C;

   // reset values and vector address
   localparam logic [7:0] RST_ZERO  = 8'h00;
   localparam logic [7:0] RST_ONES  = 8'hFF;
   localparam logic [9:0] PC_RESET  = 10'h000;
   localparam logic [9:0] PC_VECTOR = 10'h008;

   // field positions
   localparam int CMD_SLEEP  = 0;
   localparam int CMD_ENI    = 1;
   localparam int CMD_GLOBAL_IRQ_DISABLE_INSTR   = 2;
   localparam int CMD_WDTC   = 3;
   localparam int TOPT_GIE   = 6;
   localparam int FLG_PCHG   = 1;
   localparam int FLG_CMP    = 2;
   localparam int WDT_EN     = 3;
   localparam int WAKE_PCHG  = 4;
   localparam int WAKE_CMP   = 2;
   localparam int STAT_TO    = 4;
   localparam int STAT_PD    = 3;
   localparam int P5_OUT_LO  = 2;
   localparam int P5_OUT_HI  = 3;

   // oscillator mode codes
   localparam logic [1:0] OSC_IRC  = 2'h0;
   localparam logic [1:0] OSC_HIGH_SPEED_CRYSTAL_MODE = 2'h1;
   localparam logic [1:0] OSC_LOW_SPEED_CRYSTAL_MODE = 2'h2;

   // times as printed, and cycle counts at the clock rate
   localparam int CLK_KHZ     = 50000;
   localparam int RST_HOLD_MS = 18;
   localparam int LXT_RST_MS  = 500;
   localparam int WDT_TO_MS   = 18;
   localparam int IRC_WAKE_US = 10;
   localparam int HXT_WAKE_US = 800;
   localparam int LXT_WAKE_S  = 2;
   localparam int RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
   localparam int LXT_RST_CYC  = LXT_RST_MS * CLK_KHZ;
   localparam int WDT_TO_CYC   = WDT_TO_MS * CLK_KHZ;
   localparam int IRC_WAKE_CYC = (IRC_WAKE_US * CLK_KHZ + 999) / 1000;
   localparam int HXT_WAKE_CYC = (HXT_WAKE_US * CLK_KHZ + 999) / 1000;
   localparam int LXT_WAKE_CYC = LXT_WAKE_S * CLK_KHZ * 1000;

   typedef enum logic [1:0] {
      S_RST,
      S_RUN,
      S_SLEEP,
      S_WAKE
   } rwc_state_e;

   // mapped word address check, shared by write and read paths
   function automatic logic rwc_hit(input logic [AW-1:0] a);
      return (a[1:0] == 2'h0) && (a <= OFF_LAST);
   endfunction

endpackage

// >>> rtl/rwc_timer.sv
// loadable down-counter for reset hold and wake-up delay
`timescale 1ns/1ps
module rwc_timer #(
   parameter int W = 32
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              done
);
   logic [W-1:0] cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= load_val;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign done = !load && (cnt == '0);
endmodule

// >>> rtl/rwc_chg_det.sv
// input change detector against a snapshot taken at port read
`timescale 1ns/1ps
module rwc_chg_det #(
   parameter int W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         snap,
   input  wire logic [W-1:0] pins,
   output logic              chg
);
   logic [W-1:0] held;
   logic         diff_q;
   wire          diff = (pins != held);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held   <= '0;
         diff_q <= 1'b0;
      end else begin
         if (snap) begin
            held <= pins;
         end
         diff_q <= diff && !snap;
      end
   end

   // one pulse when a mismatch first appears
   assign chg = diff && !snap && !diff_q;
endmodule

// >>> sim/rwc_chk_sva.sv
// port-level concurrent checks of the reset and wake controller
`timescale 1ns/1ps
module rwc_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        ext_reset_n,
   input wire logic [31:0] port_oe_n,
   input wire logic [7:0]  pad_pullhigh,
   input wire logic [7:0]  pad_pulldown,
   input wire logic [7:0]  pad_opendrain,
   input wire logic        cpu_hold,
   input wire logic        osc_run,
   input wire logic        tick_run
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   chk_wr_answer: assert property (
      awvalid && wvalid && !awready && !bvalid |=> awready && wready && bvalid)
      else $error("write not answered in one cycle");
   chk_rd_answer: assert property (
      arvalid && !arready && !rvalid |=> arready && rvalid)
      else $error("read not answered in one cycle");
   chk_reset_init: assert property (disable iff (1'b0)
      !aresetn |=> port_oe_n == '1 && (pad_pullhigh & pad_pulldown & pad_opendrain) == 8'hFF)
      else $error("pins or pads not initialised by reset");
   chk_ext_hold: assert property (
      !ext_reset_n |=> cpu_hold)
      else $error("reset pin did not hold the core");
   chk_hold_time: assert property (
      $rose(ext_reset_n) |-> cpu_hold [*8])
      else $error("reset hold ended too early");
   chk_sleep_stop: assert property (
      !osc_run |-> cpu_hold && !tick_run)
      else $error("core or ticks running in sleep");
   chk_wake_settle: assert property (
      $rose(osc_run) |-> cpu_hold ##1 cpu_hold [*8])
      else $error("core released before oscillator settled");
   chk_p5_drive: assert property (
      tick_run ##1 tick_run |-> port_oe_n[3:2] == 2'b00)
      else $error("output-only port5 pins not driven");
endmodule
bind rwc_top rwc_chk chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
   .arvalid, .arready, .rvalid, .ext_reset_n, .port_oe_n, .pad_pullhigh, .pad_pulldown,
   .pad_opendrain, .cpu_hold, .osc_run, .tick_run);

// >>> sim/rwc_pins.sv
// pin-side model: reset switch, comparator and port pins
`timescale 1ns/1ps
module rwc_pins (
   input  wire logic  aclk,
   output logic       ext_reset_n,
   output logic       comparator_out,
   output logic [31:0] port_in
);
   initial begin
      ext_reset_n    = 1'b1;
      comparator_out = 1'b0;
      port_in        = 32'h5A3C_0F96;
   end
   task automatic pulse_reset(input int len);
      @(posedge aclk);
      ext_reset_n <= 1'b0;
      repeat (len) @(posedge aclk);
      ext_reset_n <= 1'b1;
   endtask
   task automatic flip_port6();
      @(posedge aclk);
      port_in[8] <= ~port_in[8];
   endtask
   task automatic flip_cmp();
      @(posedge aclk);
      comparator_out <= ~comparator_out;
   endtask
endmodule

// >>> sim/test_rwc_top.sv
// self-checking bench of the reset and wake controller
`timescale 1ns/1ps
module test_rwc_top
   import rwc_pkg::*;
   ();
   logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic          bvalid, arready, rvalid, ext_reset_n, comparator_out, cpu_hold, osc_run;
   logic          tick_run, pc_load;
   logic [AW-1:0] awaddr, araddr;
   logic [31:0]   wdata, rdata, port_in, port_out, port_oe_n, rd_v;
   logic [3:0]    wstrb;
   logic [1:0]    bresp, rresp, rd_r;
   logic [7:0]    pad_pullhigh, pad_pulldown, pad_opendrain;
   logic [9:0]    program_counter;
   int            err_count, compares, c;
   rwc_top #(.RST_CYC(20), .LRST_CYC(30), .WDT_CYC(50), .HWAKE_CYC(40), .LWAKE_CYC(60)) dut_u (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .ext_reset_n, .comparator_out, .port_in, .port_out, .port_oe_n, .pad_pullhigh,
      .pad_pulldown, .pad_opendrain, .cpu_hold, .osc_run, .tick_run, .pc_load, .program_counter);
   rwc_pins pins_u (.aclk, .ext_reset_n, .comparator_out, .port_in);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   initial begin
      #200us;
      err_count++;
      give_verdict();
   end
   task automatic give_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      @(posedge aclk);
      while (awready !== 1'b1) @(posedge aclk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      bready  <= 1'b1;
      @(posedge aclk);
      while (bvalid !== 1'b1) @(posedge aclk);
      rd_r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rd_v = rdata;
      rd_r = rresp;
      rready  <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wait_lvl(ref logic s, input logic v);
      for (c = 0; s !== v; c++) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_vals();
      logic [AW-1:0] offs [9] = '{OFF_PHI, OFF_PLO, OFF_ODR, OFF_TOPT, OFF_IFLG, OFF_WDT, OFF_IEN,
                                  OFF_BANK, OFF_DIR};
      logic [7:0]    exps [9] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
      for (int i = 0; i < 9; i++) begin
         rd(offs[i]);
         chk("reg reset value", rd_v, {24'h000000, exps[i]});
      end
      rd(8'h50);
      chk("unmapped resp", {30'h0, rd_r}, 32'h2);
      wr(8'h50, 8'h00);
      chk("unmapped wr resp", {30'h0, rd_r}, 32'h2);
   endtask
   task automatic t_ports();
      wr(OFF_DATA, 8'hA5);
      wr(OFF_DIR, 8'h00);
      chk("port5 out", {24'h0, port_out[7:0]}, 32'hA5);
      chk("port5 driven", {24'h0, port_oe_n[7:0]}, 32'h00);
      rd(OFF_DIR);
      chk("port5 dir", rd_v, 32'h00);
      wr(OFF_DIR, 8'hFF);
      chk("port5 input", {24'h0, port_oe_n[7:0]}, 32'hF3);
      wstrb <= 4'h0;
      wr(OFF_DIR, 8'h00);
      wstrb <= 4'hF;
      rd(OFF_DIR);
      chk("strobe off", rd_v, 32'hFF);
   endtask
   task automatic t_ext_reset(input logic [7:0] osc, input int hold);
      wr(OFF_OSC, osc);
      wr(OFF_PHI, 8'h00);
      wr(OFF_BANK, 8'h05);
      wr(OFF_TOPT, 8'h4F);
      pins_u.flip_port6();
      pins_u.pulse_reset(3);
      chk("held", {31'h0, cpu_hold}, 32'h1);
      wait_lvl(pc_load, 1'b1);
      chk("hold length", {31'h0, c >= hold && c <= hold + 4}, 32'h1);
      chk("restart pc", {22'h0, program_counter}, {22'h0, PC_RESET});
      chk("pins input", port_oe_n, 32'hFFFF_FFF3);
      rd(OFF_PHI);
      chk("pullhigh", rd_v, 32'hFF);
      rd(OFF_BANK);
      chk("bank kept", rd_v, 32'h05);
      rd(OFF_TOPT);
      chk("timer opt", rd_v, 32'h40);
   endtask
   task automatic t_run_irq();
      rd(OFF_DATA + 8'h04);
      wr(OFF_CMD, 8'h02);
      wr(OFF_IEN, 8'h02);
      pins_u.flip_port6();
      wait_lvl(pc_load, 1'b1);
      chk("run vector", {22'h0, program_counter}, {22'h0, PC_VECTOR});
      rd(OFF_IFLG);
      chk("change flag", rd_v & 32'h02, 32'h02);
      wr(OFF_IFLG, 8'h02);
   endtask
   task automatic t_wake_pin();
      wr(OFF_WDT, 8'h00);
      rd(OFF_DATA + 8'h04);
      wr(OFF_CMD, 8'h02);
      wr(OFF_WAKE, 8'h10);
      wr(OFF_IEN, 8'h02);
      wr(OFF_CMD, 8'h01);
      chk("asleep", {29'h0, osc_run, tick_run, cpu_hold}, 32'h1);
      pins_u.flip_port6();
      wait_lvl(osc_run, 1'b1);
      wait_lvl(cpu_hold, 1'b0);
      chk("irc settle", c, IRC_WAKE_CYC + 1);
      chk("wake vector", {21'h0, pc_load, program_counter}, {22'h1, PC_VECTOR});
   endtask
   task automatic t_wdt_block();
      wr(OFF_WAKE, 8'h04);
      wr(OFF_WDT, 8'h08);
      wr(OFF_CMD, 8'h01);
      pins_u.flip_cmp();
      repeat (10) @(posedge aclk);
      chk("wake masked", {31'h0, osc_run}, 32'h0);
      wait_lvl(pc_load, 1'b1);
      chk("wdt restart", {22'h0, program_counter}, {22'h0, PC_RESET});
      rd(OFF_STAT);
      chk("timeout flag", rd_v & 32'h10, 32'h10);
      rd(OFF_WDT);
      chk("wdt ctrl", rd_v, 32'h00);
   endtask
   task automatic t_cmp_wake();
      wr(OFF_OSC, 8'h01);
      wr(OFF_WDT, 8'h00);
      wr(OFF_CMD, 8'h08);
      wr(OFF_CMD, 8'h04);
      wr(OFF_WAKE, 8'h04);
      wr(OFF_IEN, 8'h04);
      wr(OFF_CMD, 8'h01);
      pins_u.flip_cmp();
      wait_lvl(osc_run, 1'b1);
      wait_lvl(cpu_hold, 1'b0);
      chk("hxt settle", c, 32'd41);
      chk("no vector", {31'h0, pc_load}, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      awaddr  = '0;
      araddr  = '0;
      wdata   = '0;
      wstrb   = 4'hF;
      repeat (4) @(posedge aclk);
      chk("oe_n in reset", port_oe_n, 32'hFFFF_FFFF);
      chk("pads in reset", {8'h0, pad_pullhigh, pad_pulldown, pad_opendrain}, 32'h00FF_FFFF);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_vals();
      t_ports();
      t_ext_reset(8'h00, 20);
      t_run_irq();
      t_wake_pin();
      t_wdt_block();
      t_cmp_wake();
      t_ext_reset(8'h02, 30);
      give_verdict();
   end
endmodule
